// [bench/rsq_reset_source.sv]
// Model of the external reset circuit and board test fixture.
// Assumes the bench steers it through hold_req and float_sel.
`default_nettype none
module rsq_reset_source
    import rsq_pkg::*;
(
    input  wire logic                             clk,
    input  wire logic                             hold_req,
    input  wire logic                             float_sel,
    output var  logic                             external_reset_request_n,
    output var  logic                             emulation_float_strap_in,
    output var  logic                             bus_lock_in,
    output var  logic [rsq_pkg::UPPER_ADDR_W-1:0] upper_address_bits_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt         = 0;
    logic req_level   = 1'b0;
    logic strap_level = 1'b1;
    // ****************************************
    // Request, strap and pulled-up pins
    // ****************************************
    assign bus_lock_in = 1'b1;
    assign upper_address_bits_in = '1;
    // Request low from power-on until STRAP_CYCLES clocks after the bench lets go of hold_req
    assign external_reset_request_n = req_level;
    assign emulation_float_strap_in = strap_level;
    // Strap set long before release, kept well past it
    always @(negedge clk) begin
        if (hold_req) begin
            cnt <= 0;
            req_level <= 1'b0;
            strap_level <= ~float_sel;
        end else if (cnt < 4 * STRAP_CYCLES) begin
            cnt <= cnt + 1;
            if (cnt == STRAP_CYCLES - 1) req_level <= 1'b1;
        end else begin
            strap_level <= 1'b1; // Back to pull-up level
        end
    end
endmodule
`default_nettype wire

// [bench/tb_reset_entry_and_emulation_strap.sv]
// Self-checking bench for the reset entry block.
// Assumes a 40 MHz clock and the reset source model beside the block.
`default_nettype none
module tb_reset_entry_and_emulation_strap;
    timeunit 1ns;
    timeprecision 1ps;
    import rsq_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, bus_active = 1'b0, hold_req = 1'b1, float_sel = 1'b0;
    logic external_reset_request_n, emulation_float_strap_in, bus_lock_in, core_reset, bus_abort;
    logic ctrl_force_inactive, ctrl_oe_b, strap_pins_oe_b, strap_pullup_en, on_circuit_float_mode, strap_fault;
    logic [UPPER_ADDR_W-1:0] upper_address_bits_in;
    int   compares = 0, miscompares = 0, cycles = 0;
    // ****************************************
    // Block, partner and clock
    // ****************************************
    rsq_reset_entry u_dut (.clk, .rst_b, .external_reset_request_n, .bus_active, .emulation_float_strap_in,
        .bus_lock_in, .upper_address_bits_in, .core_reset, .bus_abort, .ctrl_force_inactive, .ctrl_oe_b,
        .strap_pins_oe_b, .strap_pullup_en, .on_circuit_float_mode, .strap_fault);
    rsq_reset_source u_src (.clk, .hold_req, .float_sel, .external_reset_request_n, .emulation_float_strap_in,
        .bus_lock_in, .upper_address_bits_in);
    initial forever #12.5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Wait for the request pin to reach a level, bounded
    task automatic wait_req(input logic lvl);
        for (int n = 0; n < 20 && external_reset_request_n !== lvl; n++) begin
            @(negedge clk);
            #1;
        end
        check("request", external_reset_request_n, lvl);
    endtask
    // Reset entry during or outside a bus cycle, from either mode
    task automatic enter_reset(input logic busy, input logic fm);
        @(negedge clk);
        bus_active <= busy;
        hold_req <= 1'b1;
        wait_req(1'b0);
        for (int i = 0; i <= 4; i++) begin
            @(negedge clk);
            check("core_reset", core_reset, i >= 2);
            check("bus_abort", bus_abort, busy && i == 2);
            check("force", ctrl_force_inactive, i >= 2);
            check("ctrl_oe_b", ctrl_oe_b, i >= 3 || fm);
            check("pins_oe_b", strap_pins_oe_b, i >= 3 || fm);
            check("pullup", strap_pullup_en, i >= 3);
        end
        bus_active <= 1'b0;
    endtask
    // Release with the strap low or high
    task automatic leave_reset(input logic fm);
        @(negedge clk);
        float_sel <= fm;
        @(negedge clk);
        hold_req <= 1'b0;
        wait_req(1'b1);
        for (int i = 0; i <= 4; i++) begin
            @(negedge clk);
            check("core_reset", core_reset, i < 3);
        end
        check("float_mode", on_circuit_float_mode, fm);
        check("pullup", strap_pullup_en, 1'b0);
        check("force", ctrl_force_inactive, 1'b0);
        check("ctrl_oe_b", ctrl_oe_b, fm);
        check("pins_oe_b", strap_pins_oe_b, fm);
        repeat (8) @(negedge clk);
        check("float_held", on_circuit_float_mode, fm);
    endtask
    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        check("core_reset", core_reset, 1'b1);
        check("ctrl_oe_b", ctrl_oe_b, 1'b0);
        check("pullup", strap_pullup_en, 1'b1);
        rst_b <= 1'b1;
        @(negedge clk);
        check("ctrl_oe_b", ctrl_oe_b, 1'b1);
        leave_reset(1'b0);
        enter_reset(1'b1, 1'b0);
        leave_reset(1'b1);
        enter_reset(1'b0, 1'b1);
        leave_reset(1'b0);
        check("fault", strap_fault, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire

// [design/rsq_pkg.sv]
// Package for the reset entry and emulation strap block.
// Assumes a single 40 MHz clock and no software-visible registers.
`default_nettype none
package rsq_pkg;
    // Clock period in ns and the strap setup/hold time (two clock-output periods)
    localparam int CLK_PERIOD_NS   = 25;
    localparam int STRAP_WINDOW_NS = 50;
    localparam int STRAP_CYCLES    = (STRAP_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Synchroniser depth
    localparam int SYNC_STAGES     = 2;
    // Width of the upper address group
    localparam int UPPER_ADDR_W    = 3;
    // Reset values
    localparam logic RST_FLOAT_MODE = 1'b0;

    // Reset sequence states
    typedef enum logic [1:0] {
        RSQ_RUN     = 2'b00,
        RSQ_DRIVE   = 2'b01,
        RSQ_FLOAT   = 2'b10,
        RSQ_RELEASE = 2'b11
    } rsq_state_e;
endpackage
`default_nettype wire

// [design/rsq_reset_entry.sv]
// Reset entry logic: synchronises the external reset request, parks the bus,
// turns strap pins into pulled-up inputs and latches the emulation strap.
// Assumes all inputs synchronous to clk except the external reset request.
`default_nettype none

module rsq_reset_entry
    import rsq_pkg::*;
(
    input  wire logic                             clk,
    input  wire logic                             rst_b,
    input  wire logic                             external_reset_request_n,
    input  wire logic                             bus_active,
    input  wire logic                             emulation_float_strap_in,
    input  wire logic                             bus_lock_in,
    input  wire logic [rsq_pkg::UPPER_ADDR_W-1:0] upper_address_bits_in,
    output var  logic                             core_reset,
    output var  logic                             bus_abort,
    output var  logic                             ctrl_force_inactive,
    output var  logic                             ctrl_oe_b,
    output var  logic                             strap_pins_oe_b,
    output var  logic                             strap_pullup_en,
    output var  logic                             on_circuit_float_mode,
    output var  logic                             strap_fault
);
    import rsq_pkg::*;

    // ************************************************************
    // State record
    // ************************************************************
    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        rsq_state_e             state;
        logic                   core_reset;
        logic                   bus_abort;
        logic                   ctrl_force_inactive;
        logic                   ctrl_oe_b;
        logic                   strap_pins_oe_b;
        logic                   strap_pullup_en;
        logic                   float_mode;
        logic                   strap_fault;
    } rsq_state_s;

    rsq_state_s r;
    rsq_state_s next_r;
    logic       reset_seen;

    // Synchronised reset request level, taken from the last stage only
    assign reset_seen = ~r.sync[SYNC_STAGES-1];

    // ************************************************************
    // Next state
    // ************************************************************
    // Sequence: drive controls inactive, float them, hold, then release
    always_comb begin
        next_r = r;
        // Shift the request through the synchroniser
        next_r.sync = {r.sync[SYNC_STAGES-2:0], external_reset_request_n};
        next_r.bus_abort = 1'b0;
        case (r.state)
            RSQ_RUN: begin
                if (reset_seen) begin
                    next_r.state               = RSQ_DRIVE;
                    next_r.core_reset          = 1'b1;
                    next_r.bus_abort           = bus_active;
                    next_r.ctrl_force_inactive = 1'b1;
                end
            end
            RSQ_DRIVE: begin
                // Controls held inactive one cycle before floating
                next_r.state           = RSQ_FLOAT;
                next_r.ctrl_oe_b       = 1'b1;
                next_r.strap_pins_oe_b = 1'b1;
                next_r.strap_pullup_en = 1'b1;
            end
            RSQ_FLOAT: begin
                // Watch for forbidden low levels on lock and upper address
                if (!bus_lock_in || (upper_address_bits_in != '1)) begin
                    next_r.strap_fault = 1'b1;
                end
                if (!reset_seen) begin
                    next_r.state      = RSQ_RELEASE;
                    next_r.float_mode = ~emulation_float_strap_in;
                end
            end
            RSQ_RELEASE: begin
                if (reset_seen) begin
                    next_r.state = RSQ_FLOAT;
                end else begin
                    next_r.state               = RSQ_RUN;
                    next_r.core_reset          = 1'b0;
                    next_r.strap_pullup_en     = 1'b0;
                    next_r.ctrl_force_inactive = 1'b0;
                    // In float mode the outputs stay released
                    next_r.ctrl_oe_b           = r.float_mode;
                    next_r.strap_pins_oe_b     = r.float_mode;
                end
            end
            default: begin
                next_r.state = RSQ_DRIVE;
            end
        endcase
        // Float mode keeps pins released until next reset
        if (r.state == RSQ_RUN && r.float_mode && !reset_seen) begin
            next_r.ctrl_oe_b       = 1'b1;
            next_r.strap_pins_oe_b = 1'b1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r.sync                <= '0;
            r.state               <= RSQ_DRIVE;
            r.core_reset          <= 1'b1;
            r.bus_abort           <= 1'b0;
            r.ctrl_force_inactive <= 1'b1;
            r.ctrl_oe_b           <= 1'b0;
            r.strap_pins_oe_b     <= 1'b1;
            r.strap_pullup_en     <= 1'b1;
            r.float_mode          <= RST_FLOAT_MODE;
            r.strap_fault         <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign core_reset            = r.core_reset;
    assign bus_abort             = r.bus_abort;
    assign ctrl_force_inactive   = r.ctrl_force_inactive;
    assign ctrl_oe_b             = r.ctrl_oe_b;
    assign strap_pins_oe_b       = r.strap_pins_oe_b;
    assign strap_pullup_en       = r.strap_pullup_en;
    assign on_circuit_float_mode = r.float_mode;
    assign strap_fault           = r.strap_fault;

    // ************************************************************
    // Assertions
    // ************************************************************
    reset_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r.state == RSQ_RUN && reset_seen) |=> core_reset && ctrl_force_inactive)
        else $error("Reset request did not start reset");
    sync_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(external_reset_request_n) && r.state == RSQ_RUN |-> ##2 reset_seen)
        else $error("Synchroniser delay wrong");
    sync_two_a: assert property (@(posedge clk) disable iff (!rst_b)
        r.sync[SYNC_STAGES-1] == $past(r.sync[0]))
        else $error("Synchroniser stages not in series");
    abort_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        bus_abort |-> core_reset && !$past(bus_abort))
        else $error("Bus abort not a single pulse in reset");
    drive_first_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(ctrl_oe_b) && core_reset |-> $past(ctrl_force_inactive))
        else $error("Controls floated before driven inactive");
    float_order_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r.state == RSQ_DRIVE) |=> ctrl_oe_b)
        else $error("Controls not floated after drive");
    pullup_in_a: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == RSQ_FLOAT |-> strap_pullup_en && strap_pins_oe_b)
        else $error("Strap pins not pulled-up inputs");
    strap_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r.state == RSQ_FLOAT && !reset_seen) |=> on_circuit_float_mode == !$past(emulation_float_strap_in))
        else $error("Strap not latched at release");
    mode_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r.state == RSQ_RUN && on_circuit_float_mode) |-> ctrl_oe_b && $stable(on_circuit_float_mode))
        else $error("Float mode not held");

    // Entry, release and strap-window checks
    abort_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r.state == RSQ_RUN && reset_seen) |=> bus_abort == $past(bus_active))
        else $error("Bus abort does not follow bus activity");
    entry_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r.state == RSQ_RUN && reset_seen) |=> $stable(ctrl_oe_b))
        else $error("Controls floated at reset entry");
    hold_inputs_a: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == RSQ_RELEASE |-> strap_pullup_en && strap_pins_oe_b)
        else $error("Strap pins not inputs at release");
    pullup_run_a: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == RSQ_RUN |-> !strap_pullup_en)
        else $error("Pull-ups left on after reset");
    fault_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        strap_fault |=> strap_fault)
        else $error("Strap fault flag not sticky");
    core_state_a: assert property (@(posedge clk) disable iff (!rst_b)
        core_reset == (r.state != RSQ_RUN))
        else $error("Core reset out of step with sequence");
    sync_fresh_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> r.sync[0] == $past(external_reset_request_n))
        else $error("First synchroniser stage not fed by request");
    release_run_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r.state == RSQ_RELEASE && !reset_seen) |=>
            !core_reset && ctrl_oe_b == on_circuit_float_mode && strap_pins_oe_b == on_circuit_float_mode)
        else $error("Outputs wrong after release");
    mode_change_a: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(on_circuit_float_mode) |-> r.state == RSQ_RELEASE)
        else $error("Float mode changed outside release");

    // ************************************************************
    // Scenario covers
    // ************************************************************
    warm_reset_c: cover property (@(posedge clk) disable iff (!rst_b)
        r.state == RSQ_RUN ##1 r.state == RSQ_DRIVE);
    float_mode_c: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(on_circuit_float_mode));
    abort_c: cover property (@(posedge clk) disable iff (!rst_b) bus_abort);
    fault_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(strap_fault));
    release_c: cover property (@(posedge clk) disable iff (!rst_b)
        r.state == RSQ_RELEASE ##1 r.state == RSQ_RUN);
endmodule
`default_nettype wire

// [design/unused_placeholder_none.sv]
// Intentionally empty design unit list.
`default_nettype none
`default_nettype wire
